// ===== verilog/dbg_status_pkg.sv
/*
  Constants for the debug port system control and status block: register
  offsets, field positions, reset values, codes and timing.
  Assumes a simple byte-wide register port driven by the access layer.
*/
package dbg_status_pkg;
  localparam logic [3:0] OFS_PORT_CLOCK_CONTROL = 4'h9;
  localparam logic [3:0] OFS_SYSTEM_CONTROL_A = 4'hA;
  localparam logic [3:0] OFS_SYSTEM_STATUS = 4'hB;
  localparam logic [3:0] OFS_CRC_STATUS = 4'hC;
  localparam logic [3:0] OFS_RESET_REQUEST = 4'h8;
  localparam logic [1:0] DIV_32MHZ = 2'h0;
  localparam logic [1:0] DIV_16MHZ = 2'h1;
  localparam logic [1:0] DIV_8MHZ = 2'h2;
  localparam logic [1:0] DIV_4MHZ = 2'h3;
  localparam logic [1:0] DIV_RESET = DIV_4MHZ;
  localparam logic [7:0] RESET_CODE_HOLD = 8'h59;
  localparam logic [7:0] RESET_CODE_RUN = 8'h00;
  localparam int CTRL_SYSTEM_CLOCK_REQUEST_BIT = 0;
  localparam int CTRL_USER_ROW_DONE_BIT = 1;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_BOOT_BIT = 1;
  localparam int ST_USER_ROW_PROGRAM_START_BIT = 2;
  localparam int ST_NVM_PROGRAM_START_BIT = 3;
  localparam int ST_SLEEP_BIT = 4;
  localparam int ST_SYSTEM_RESET_ACTIVE_BIT = 5;
  localparam int ST_ERASE_FAILED_FLAG_BIT = 6;
  localparam int ST_BOOT_DONE_OR_ERASE_FAILED_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [2:0] CRC_OFF = 3'h0;
  localparam logic [2:0] CRC_BUSY = 3'h1;
  localparam logic [2:0] CRC_GOOD = 3'h2;
  localparam logic [2:0] CRC_FAIL = 3'h4;
  localparam int ROOT_CLOCK_MHZ = 32;
  localparam int MCLK_MHZ = 125;
  localparam logic [2:0] SYNC_SETTLE_CYCLES = 3'h4;
endpackage : dbg_status_pkg

// ===== verilog/dbg_sync_if.sv
/*
  Bundle of synchronised system-domain status levels passed from the
  input synchroniser to the register block.
  Assumes both ends run on mclk.
*/
`timescale 1ns/100ps
interface dbg_sync_if;
  logic sysInReset;
  logic sysSleeping;
  logic boot_sequence_done;
  logic eraseFailEvt;
  logic nvmLocked;
  logic nvm_program_start;
  logic user_row_program_start;
  modport source (output sysInReset, sysSleeping, boot_sequence_done, eraseFailEvt, nvmLocked, nvm_program_start, user_row_program_start);
  modport sink (input sysInReset, sysSleeping, boot_sequence_done, eraseFailEvt, nvmLocked, nvm_program_start, user_row_program_start);
endinterface : dbg_sync_if

// ===== verilog/status_sync.sv
/*
  Three-stage synchronisers for system-domain status levels; a level is
  accepted once stages two and three agree.
  Assumes inputs are asynchronous to mclk.
*/
`timescale 1ns/100ps
module status_sync
#(
  parameter int WIDTH = 7
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_syncOut;

  // =====================================================
  // filter: hold the old value while the two stages differ
  always_comb
  begin
    next_syncOut = syncOut;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2[i] == stage3[i])
        next_syncOut[i] = stage3[i];
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1 <= rawIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= next_syncOut;
    end
  end
endmodule : status_sync

// ===== verilog/debug_port_system_status_ctrl.sv
/*
  System-side control and status registers of the debug port access layer:
  clock divider, system clock request, user row handshake, reset request,
  system status and CRC status.
  Assumes a byte register port from the access layer, level status inputs
  from the system domain (asynchronous) and CRC status from mclk logic.
*/
`timescale 1ns/100ps
module debug_port_system_status_ctrl
  import dbg_status_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic portEnable,
  input wire logic userRowKeyOk,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic sysResetIn,
  input wire logic sysSleepIn,
  input wire logic bootDoneIn,
  input wire logic eraseFailIn,
  input wire logic nvmLockedIn,
  input wire logic progStartIn,
  input wire logic urowStartIn,
  input wire logic [2:0] crcState,
  output logic [1:0] debugClockDividerSelect,
  output logic systemClockRequest,
  output logic userRowDoneStart,
  output logic systemResetHold,
  output logic accessGranted
);
  dbg_sync_if syncBus ();

  status_sync #(.WIDTH(7)) uSync
  (
    .mclk(mclk),
    .resetn(resetn),
    .rawIn({urowStartIn, progStartIn, nvmLockedIn, eraseFailIn, bootDoneIn, sysSleepIn, sysResetIn}),
    .syncOut({syncBus.user_row_program_start, syncBus.nvm_program_start, syncBus.nvmLocked, syncBus.eraseFailEvt,
      syncBus.boot_sequence_done, syncBus.sysSleeping, syncBus.sysInReset})
  );

  // =====================================================
  // register state
  logic portEnableQ;
  logic eraseFailed;
  logic sysRstFlag;
  logic lockFlag;
  logic [2:0] crcReg;
  logic [1:0] next_div;
  logic next_system_clock_request;
  logic next_user_row_done;
  logic next_rstHold;
  logic next_eraseFailed;
  logic next_sysRstFlag;
  logic next_lockFlag;
  logic [2:0] next_crcReg;
  logic [7:0] next_rdata;
  logic next_access;
  logic [7:0] statusVal;
  logic [2:0] settleCnt;
  logic [2:0] next_settleCnt;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb
  begin
    statusVal = 8'h00;
    statusVal[ST_BOOT_DONE_OR_ERASE_FAILED_BIT] = eraseFailed | syncBus.boot_sequence_done;
    statusVal[ST_ERASE_FAILED_FLAG_BIT] = eraseFailed;
    statusVal[ST_SYSTEM_RESET_ACTIVE_BIT] = sysRstFlag;
    statusVal[ST_SLEEP_BIT] = syncBus.sysSleeping;
    statusVal[ST_NVM_PROGRAM_START_BIT] = syncBus.nvm_program_start;
    statusVal[ST_USER_ROW_PROGRAM_START_BIT] = syncBus.user_row_program_start;
    statusVal[ST_BOOT_BIT] = syncBus.boot_sequence_done;
    statusVal[ST_LOCK_BIT] = lockFlag;
  end

  // =====================================================
  // next-state logic
  always_comb
  begin
    next_div = debugClockDividerSelect;
    next_system_clock_request = systemClockRequest;
    next_user_row_done = 1'b0;
    next_rstHold = systemResetHold;
    next_eraseFailed = eraseFailed;
    next_sysRstFlag = sysRstFlag;
    next_lockFlag = lockFlag;
    next_settleCnt = settleCnt;
    next_crcReg = crcReg;
    next_rdata = regRdata;
    next_access = syncBus.boot_sequence_done;
    if (regWrite && hit(regAddr, OFS_PORT_CLOCK_CONTROL))
      next_div = regWdata[1:0];
    if (regWrite && hit(regAddr, OFS_SYSTEM_CONTROL_A))
    begin
      next_system_clock_request = regWdata[CTRL_SYSTEM_CLOCK_REQUEST_BIT];
      // the pulse fires only while userRowKeyOk is set, so writes without the key leave it low
      if (userRowKeyOk)
        next_user_row_done = regWdata[CTRL_USER_ROW_DONE_BIT];
    end
    if (regWrite && hit(regAddr, OFS_RESET_REQUEST))
    begin
      if (regWdata == RESET_CODE_HOLD)
        next_rstHold = 1'b1;
      else if (regWdata == RESET_CODE_RUN)
        next_rstHold = 1'b0;
    end
    if (portEnable && !portEnableQ)
    begin
      next_div = DIV_RESET;
      next_system_clock_request = 1'b1;
    end
    if (regRead && hit(regAddr, OFS_SYSTEM_STATUS))
      next_sysRstFlag = 1'b0;
    // set wins over the read clear
    if (syncBus.sysInReset || systemResetHold)
      next_sysRstFlag = 1'b1;
    if (syncBus.sysInReset || systemResetHold)
      next_eraseFailed = 1'b0;
    else if (syncBus.eraseFailEvt)
      next_eraseFailed = 1'b1;
    // the synchroniser comes out of reset empty; the lock flag keeps its reset
    // value until the input has had time to arrive, so a locked part never reads unlocked
    if (settleCnt != SYNC_SETTLE_CYCLES)
      next_settleCnt = settleCnt + 3'h1;
    else
      next_lockFlag = syncBus.nvmLocked;
    unique case (crcState)
      CRC_OFF, CRC_BUSY, CRC_GOOD, CRC_FAIL: next_crcReg = crcState;
      default: next_crcReg = crcReg;
    endcase
    if (regRead)
    begin
      if (hit(regAddr, OFS_PORT_CLOCK_CONTROL))
        next_rdata = {6'h00, debugClockDividerSelect};
      else if (hit(regAddr, OFS_SYSTEM_CONTROL_A))
        next_rdata = {7'h00, systemClockRequest};
      else if (hit(regAddr, OFS_SYSTEM_STATUS))
        next_rdata = statusVal;
      else if (hit(regAddr, OFS_CRC_STATUS))
        next_rdata = {5'h00, crcReg};
      else if (hit(regAddr, OFS_RESET_REQUEST))
        next_rdata = systemResetHold ? RESET_CODE_HOLD : RESET_CODE_RUN;
      else
        next_rdata = 8'h00;
    end
  end

  // =====================================================
  // registers; the port reset is independent of the system reset hold
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      portEnableQ <= 1'b0;
      debugClockDividerSelect <= DIV_RESET;
      systemClockRequest <= 1'b0;
      userRowDoneStart <= 1'b0;
      systemResetHold <= 1'b0;
      eraseFailed <= 1'b0;
      sysRstFlag <= 1'b0;
      lockFlag <= STATUS_RESET[ST_LOCK_BIT];
      settleCnt <= 3'h0;
      crcReg <= CRC_OFF;
      regRdata <= 8'h00;
      accessGranted <= 1'b0;
    end
    else
    begin
      portEnableQ <= portEnable;
      debugClockDividerSelect <= next_div;
      systemClockRequest <= next_system_clock_request;
      userRowDoneStart <= next_user_row_done;
      systemResetHold <= next_rstHold;
      eraseFailed <= next_eraseFailed;
      sysRstFlag <= next_sysRstFlag;
      lockFlag <= next_lockFlag;
      settleCnt <= next_settleCnt;
      crcReg <= next_crcReg;
      regRdata <= next_rdata;
      accessGranted <= next_access;
    end
  end

  // =====================================================
  // checks
  a_urow_key_gate: assert property (@(posedge mclk) disable iff (!resetn)
    (regWrite && hit(regAddr, OFS_SYSTEM_CONTROL_A) && !userRowKeyOk) |=> !userRowDoneStart)
    else $error("user row done fired without key");
  a_urow_start: assert property (@(posedge mclk) disable iff (!resetn)
    (regWrite && hit(regAddr, OFS_SYSTEM_CONTROL_A) && userRowKeyOk && regWdata[CTRL_USER_ROW_DONE_BIT])
    |=> userRowDoneStart ##1 (!userRowDoneStart
    || $past(regWrite && hit(regAddr, OFS_SYSTEM_CONTROL_A) && userRowKeyOk && regWdata[CTRL_USER_ROW_DONE_BIT])))
    else $error("user row done pulse wrong");
  a_enable_system_clock_request: assert property (@(posedge mclk) disable iff (!resetn)
    (portEnable && !portEnableQ) |=> systemClockRequest && debugClockDividerSelect == DIV_4MHZ)
    else $error("enable did not set clock request and divider");
  a_system_clock_request_write: assert property (@(posedge mclk) disable iff (!resetn)
    (regWrite && hit(regAddr, OFS_SYSTEM_CONTROL_A) && !(portEnable && !portEnableQ))
    |=> systemClockRequest == $past(regWdata[CTRL_SYSTEM_CLOCK_REQUEST_BIT]))
    else $error("clock request not written");
  a_div_write: assert property (@(posedge mclk) disable iff (!resetn)
    (regWrite && hit(regAddr, OFS_PORT_CLOCK_CONTROL) && !(portEnable && !portEnableQ))
    |=> debugClockDividerSelect == $past(regWdata[1:0]))
    else $error("divider not written");
  a_reset_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (regWrite && hit(regAddr, OFS_RESET_REQUEST) && regWdata == RESET_CODE_HOLD)
    |=> systemResetHold ##1 sysRstFlag && !eraseFailed)
    else $error("reset request not held");
  a_system_reset_active_read: assert property (@(posedge mclk) disable iff (!resetn)
    (regRead && hit(regAddr, OFS_SYSTEM_STATUS) && !syncBus.sysInReset && !systemResetHold) |=> !sysRstFlag)
    else $error("reset flag not cleared on read");
  a_boot_done_or_erase_failed_or: assert property (@(posedge mclk) disable iff (!resetn)
    (regRead && hit(regAddr, OFS_SYSTEM_STATUS))
    |=> regRdata[ST_BOOT_DONE_OR_ERASE_FAILED_BIT] == ($past(eraseFailed) | $past(syncBus.boot_sequence_done)))
    else $error("status bit 7 not the or");
  a_crc_onehot: assert property (@(posedge mclk) disable iff (!resetn)
    $onehot0(crcReg))
    else $error("crc status not one-hot");

  // =====================================================
  // control and reset request checks
  a_urow_idle: assert property (@(posedge mclk) disable iff (!resetn)
    !(regWrite && hit(regAddr, OFS_SYSTEM_CONTROL_A) && userRowKeyOk)
    |=> !userRowDoneStart)
    else $error("user row done pulse without a keyed write");
  a_system_clock_request_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(regWrite && hit(regAddr, OFS_SYSTEM_CONTROL_A)) && !(portEnable && !portEnableQ)
    |=> $stable(systemClockRequest))
    else $error("clock request changed without a write");
  a_div_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(regWrite && hit(regAddr, OFS_PORT_CLOCK_CONTROL)) && !(portEnable && !portEnableQ)
    |=> $stable(debugClockDividerSelect))
    else $error("divider changed without a write");
  a_hold_release: assert property (@(posedge mclk) disable iff (!resetn)
    (regWrite && hit(regAddr, OFS_RESET_REQUEST) && regWdata == RESET_CODE_RUN)
    |=> !systemResetHold)
    else $error("reset request not released");
  a_hold_other: assert property (@(posedge mclk) disable iff (!resetn)
    !(regWrite && hit(regAddr, OFS_RESET_REQUEST) && (regWdata == RESET_CODE_HOLD || regWdata == RESET_CODE_RUN))
    |=> $stable(systemResetHold))
    else $error("reset request moved on a reserved code");
  a_system_reset_active_set: assert property (@(posedge mclk) disable iff (!resetn)
    (syncBus.sysInReset || systemResetHold)
    |=> sysRstFlag)
    else $error("reset flag not set during reset");
  a_erase_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (syncBus.sysInReset || systemResetHold)
    |=> !eraseFailed)
    else $error("erase failed flag not cleared by reset");
  a_erase_set: assert property (@(posedge mclk) disable iff (!resetn)
    (syncBus.eraseFailEvt && !syncBus.sysInReset && !systemResetHold)
    |=> eraseFailed)
    else $error("erase failed flag not set");

  // =====================================================
  // status and readback checks
  a_lock_settle: assert property (@(posedge mclk) disable iff (!resetn)
    (settleCnt != SYNC_SETTLE_CYCLES)
    |=> lockFlag)
    else $error("lock flag left its reset value too early");
  a_lock_follow: assert property (@(posedge mclk) disable iff (!resetn)
    (settleCnt == SYNC_SETTLE_CYCLES)
    |=> lockFlag == $past(syncBus.nvmLocked))
    else $error("lock flag does not follow the lock input");
  a_access_open: assert property (@(posedge mclk) disable iff (!resetn)
    syncBus.boot_sequence_done
    |=> accessGranted)
    else $error("access not granted after boot");
  a_access_closed: assert property (@(posedge mclk) disable iff (!resetn)
    !syncBus.boot_sequence_done
    |=> !accessGranted)
    else $error("access granted before boot");
  a_crc_follow: assert property (@(posedge mclk) disable iff (!resetn)
    $onehot0(crcState)
    |=> crcReg == $past(crcState))
    else $error("crc status does not follow a legal code");
  a_crc_reserved: assert property (@(posedge mclk) disable iff (!resetn)
    !$onehot0(crcState)
    |=> $stable(crcReg))
    else $error("crc status took a reserved code");
  a_ctrl_unused: assert property (@(posedge mclk) disable iff (!resetn)
    (regRead && hit(regAddr, OFS_SYSTEM_CONTROL_A))
    |=> regRdata[7:1] == 7'h00)
    else $error("control unused bits not zero");
  a_crc_unused: assert property (@(posedge mclk) disable iff (!resetn)
    (regRead && hit(regAddr, OFS_CRC_STATUS))
    |=> regRdata[7:3] == 5'h00)
    else $error("crc status unused bits not zero");
  a_sleep_read: assert property (@(posedge mclk) disable iff (!resetn)
    (regRead && hit(regAddr, OFS_SYSTEM_STATUS))
    |=> regRdata[ST_SLEEP_BIT] == $past(syncBus.sysSleeping))
    else $error("sleep flag readback wrong");
  a_start_read: assert property (@(posedge mclk) disable iff (!resetn)
    (regRead && hit(regAddr, OFS_SYSTEM_STATUS))
    |=> regRdata[ST_NVM_PROGRAM_START_BIT] == $past(syncBus.nvm_program_start) && regRdata[ST_USER_ROW_PROGRAM_START_BIT] == $past(syncBus.user_row_program_start))
    else $error("programming start flags readback wrong");
endmodule : debug_port_system_status_ctrl

// ===== tb/prog_model.sv
/*
  Programmer-side model: owns the byte register port of the status block.
  Assumes mclk from the bench; requests change only at the falling edge.
*/
`timescale 1ns/100ps
module prog_model
(
  input wire logic mclk,
  input wire logic [7:0] regRdata,
  output logic regWrite,
  output logic regRead,
  output logic [3:0] regAddr,
  output logic [7:0] regWdata
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
  end
  // ==========================================================
  // register cycles
  // entry waits a falling edge, so back-to-back calls never re-raise a strobe in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
  endtask : wr
  // data is taken one cycle after the strobe, where it is settled
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask : rd
endmodule : prog_model

// ===== tb/tb_top.sv
/*
  Self-checking bench for the debug port status block.
  Assumes the programmer model drives the register strobes.
*/
`timescale 1ns/100ps
module tb_top;
  import dbg_status_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic portEnable = 1'b0;
  logic userRowKeyOk = 1'b0;
  // reset, sleep, boot, locked, nvm_program_start, user_row_program_start, erase_failed_flag
  logic [6:0] sysIn = 7'h08;
  logic [2:0] crcState = 3'h0;
  logic regWrite;
  logic regRead;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic [7:0] rd;
  logic [1:0] divSel;
  logic system_clock_request;
  logic rowPulse;
  logic rstHold;
  logic granted;
  int miscompares = 0;
  int checked = 0;
  int pulses = 0;
  debug_port_system_status_ctrl dut_u (.mclk(mclk), .resetn(resetn), .portEnable(portEnable),
    .userRowKeyOk(userRowKeyOk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .sysResetIn(sysIn[0]), .sysSleepIn(sysIn[1]),
    .bootDoneIn(sysIn[2]), .nvmLockedIn(sysIn[3]), .progStartIn(sysIn[4]), .urowStartIn(sysIn[5]),
    .eraseFailIn(sysIn[6]), .crcState(crcState), .debugClockDividerSelect(divSel),
    .systemClockRequest(system_clock_request), .userRowDoneStart(rowPulse), .systemResetHold(rstHold),
    .accessGranted(granted));
  prog_model prog_u (.mclk(mclk), .regRdata(regRdata), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata));
  always #4 mclk = ~mclk;
  always @(posedge mclk)
    if (rowPulse === 1'b1)
      pulses <= pulses + 1;
  // ==========================================================
  // helpers
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic close_out;
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // ==========================================================
  // scenarios
  task automatic t_divider;
    chk("divider", 8'h03, {6'h0, divSel});
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", STATUS_RESET, rd);
    for (int i = 0; i < 4; i++)
    begin
      prog_u.wr(OFS_PORT_CLOCK_CONTROL, 8'(i));
      wt(1);
      chk("divider", 8'(i), {6'h0, divSel});
    end
    prog_u.wr(OFS_SYSTEM_CONTROL_A, 8'h00);
    portEnable = 1'b1;
    wt(2);
    chk("divider", 8'h03, {6'h0, divSel});
    chk("clock request", 8'h01, {7'h0, system_clock_request});
  endtask : t_divider
  task automatic t_control;
    int base;
    sysIn[1] = 1'b1;
    prog_u.wr(OFS_SYSTEM_CONTROL_A, 8'hFC);
    wt(1);
    chk("clock request", 8'h00, {7'h0, system_clock_request});
    prog_u.rd(OFS_SYSTEM_CONTROL_A, rd);
    chk("control", 8'h00, rd);
    prog_u.wr(OFS_SYSTEM_CONTROL_A, 8'hFD);
    wt(1);
    chk("clock request", 8'h01, {7'h0, system_clock_request});
    prog_u.rd(OFS_SYSTEM_CONTROL_A, rd);
    chk("control", 8'h01, rd);
    sysIn[1] = 1'b0;
    base = pulses;
    prog_u.wr(OFS_SYSTEM_CONTROL_A, 8'h03);
    wt(3);
    chk("row pulses", 8'h00, 8'(pulses - base));
    userRowKeyOk = 1'b1;
    prog_u.wr(OFS_SYSTEM_CONTROL_A, 8'h03);
    wt(3);
    chk("row pulses", 8'h01, 8'(pulses - base));
  endtask : t_control
  task automatic t_status;
    logic [7:0] expTab [6] = '{8'h20, 8'h10, 8'h82, 8'h01, 8'h08, 8'h04};
    sysIn = 7'h00;
    wt(8);
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", 8'h00, rd);
    for (int i = 1; i < 6; i++)
    begin
      sysIn = 7'(1 << i);
      wt(8);
      prog_u.rd(OFS_SYSTEM_STATUS, rd);
      chk("status", expTab[i], rd);
      chk("granted", {7'h0, i == 2}, {7'h0, granted});
      sysIn = 7'h00;
      wt(8);
    end
  endtask : t_status
  task automatic t_reset;
    sysIn = 7'h01;
    wt(8);
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", 8'h20, rd);
    sysIn = 7'h40;
    wt(8);
    sysIn = 7'h00;
    wt(8);
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", 8'hC0, rd);
    prog_u.wr(OFS_PORT_CLOCK_CONTROL, 8'h00);
    prog_u.wr(OFS_RESET_REQUEST, RESET_CODE_HOLD);
    prog_u.wr(OFS_RESET_REQUEST, 8'h33);
    wt(1);
    chk("reset hold", 8'h01, {7'h0, rstHold});
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", 8'h20, rd);
    prog_u.wr(OFS_RESET_REQUEST, RESET_CODE_RUN);
    wt(1);
    chk("reset hold", 8'h00, {7'h0, rstHold});
    chk("divider", 8'h00, {6'h0, divSel});
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", 8'h00, rd);
  endtask : t_reset
  task automatic t_crc;
    logic [2:0] codes [5] = '{CRC_OFF, CRC_BUSY, CRC_GOOD, CRC_FAIL, 3'h3};
    for (int i = 0; i < 5; i++)
    begin
      crcState = codes[i];
      wt(1);
      prog_u.rd(OFS_CRC_STATUS, rd);
      chk("crc", {5'h0, codes[i < 4 ? i : 3]}, rd);
    end
    prog_u.rd(4'hF, rd);
    chk("unmapped", 8'h00, rd);
  endtask : t_crc
  task automatic t_port_reset;
    sysIn = 7'h48;
    wt(8);
    sysIn = 7'h08;
    wt(8);
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", 8'hC1, rd);
    resetn = 1'b0;
    wt(2);
    resetn = 1'b1;
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", STATUS_RESET, rd);
    chk("divider", 8'h03, {6'h0, divSel});
    wt(8);
    prog_u.rd(OFS_SYSTEM_STATUS, rd);
    chk("status", 8'h01, rd);
  endtask : t_port_reset
  // ==========================================================
  // sequence and watchdog
  initial
  begin
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    t_divider();
    t_control();
    t_status();
    t_reset();
    t_crc();
    t_port_reset();
    close_out();
  end
  // the run needs well under 2000 cycles; allow ten times that
  initial
  begin
    #160000;
    miscompares++;
    close_out();
  end
endmodule : tb_top
